// File: logic/serial_bus_logic.sv
// Two-wire control slave: bus framing, address match and register pointer.
`timescale 1ns/1ps
module serial_bus_logic (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [1:0]  addr_strap,
	input  wire logic        dev_addr_load,
	input  wire logic [6:0]  dev_addr_new,
	input  wire logic        ctrl_bus_clk_line,
	input  wire logic        ctrl_bus_data_line_in,
	output logic             ctrl_bus_data_line_out,
	output logic             ctrl_bus_data_line_oe,
	output logic [15:0]      reg_addr,
	output logic             reg_wr_en,
	output logic [7:0]       reg_wr_data,
	output logic             reg_rd_en,
	input  wire logic [7:0]  reg_rd_data,
	output logic             bus_active
);

	// -----------------------------------------------------------------
	// Declarations
	// -----------------------------------------------------------------
	sbi_pkg::phase_t state_q;
	sbi_pkg::phase_t state_d;
	logic            scl_f;
	logic            sda_f;
	logic            scl_p_q;
	logic            sda_p_q;
	logic            sda_low_q;
	logic            sda_low_d;
	logic [3:0]      bit_cnt_q;
	logic [7:0]      shift_q;
	logic [7:0]      tx_q;
	logic [7:0]      rd_buf_q;
	logic [7:0]      wr_data_q;
	logic [15:0]     ptr_q;
	logic [6:0]      dev_addr_q;
	logic            strap_done_q;
	logic            rw_q;
	logic            mack_q;
	logic            wr_en_q;
	logic            rd_req_q;
	logic            rd_take_q;
	logic            rd_step_q;

	// Strap decode; the reserved code answers at an unused address.
	function automatic logic [6:0] strap_map(input logic [1:0] s);
		unique case (s)
			2'h0:    strap_map = sbi_pkg::STRAP0_ADDR;
			2'h1:    strap_map = sbi_pkg::STRAP1_ADDR;
			2'h2:    strap_map = sbi_pkg::STRAP2_ADDR;
			default: strap_map = sbi_pkg::STRAP_RSVD_ADDR;
		endcase
	endfunction

	// -----------------------------------------------------------------
	// Line conditioning
	// -----------------------------------------------------------------
	// filtered bus lines
	line_filter u_scl_filter (
		.clk_sys (clk_sys),
		.rst     (rst),
		.line_in (ctrl_bus_clk_line),
		.line_q  (scl_f)
	);

	line_filter u_sda_filter (
		.clk_sys (clk_sys),
		.rst     (rst),
		.line_in (ctrl_bus_data_line_in),
		.line_q  (sda_f)
	);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			scl_p_q <= sbi_pkg::LINE_IDLE;
			sda_p_q <= sbi_pkg::LINE_IDLE;
		end else begin
			scl_p_q <= scl_f;
			sda_p_q <= sda_f;
		end
	end

	// -----------------------------------------------------------------
	// Bus events and decodes
	// -----------------------------------------------------------------
	// Both lines pass through the same filter, so their relative order is
	// preserved and a data change inside a clock high phase is seen as such.
	wire scl_rise  = scl_f & ~scl_p_q;
	wire scl_fall  = ~scl_f & scl_p_q;
	wire start_det = scl_f & scl_p_q & sda_p_q & ~sda_f;
	wire stop_det  = scl_f & scl_p_q & ~sda_p_q & sda_f;
	wire byte_end  = scl_fall & (bit_cnt_q == sbi_pkg::BYTE_BITS);
	wire addr_hit  = (shift_q[7:1] == dev_addr_q) | (shift_q[7:1] == sbi_pkg::BCAST_ADDR);
	wire in_dev    = (state_q == sbi_pkg::ST_DEV);
	wire in_rdack  = (state_q == sbi_pkg::ST_RD_ACK);
	wire in_wrack  = (state_q == sbi_pkg::ST_WR_ACK);
	wire in_byte   = in_dev | (state_q == sbi_pkg::ST_PTR_HI) | (state_q == sbi_pkg::ST_PTR_LO)
		| (state_q == sbi_pkg::ST_WDATA) | (state_q == sbi_pkg::ST_RDATA);
	// step at the rising clock that opens the acknowledge bit
	wire ptr_step  = scl_rise & (in_wrack | in_rdack);
	// read request with least bit set
	wire dev_read  = byte_end & in_dev & addr_hit & shift_q[0];

	assign ctrl_bus_data_line_out = 1'b0;
	assign ctrl_bus_data_line_oe  = sda_low_q;
	assign reg_addr               = ptr_q;
	assign reg_wr_en              = wr_en_q;
	assign reg_wr_data            = wr_data_q;
	assign reg_rd_en              = rd_req_q;
	assign bus_active             = (state_q != sbi_pkg::ST_IDLE);

	// -----------------------------------------------------------------
	// Phase sequencing and data line drive
	// -----------------------------------------------------------------
	// Drive is taken only on a falling clock and dropped there or at START and STOP, so the slave itself never
	// starts pulling the data line low while the clock is high.
	always_comb begin
		state_d   = state_q;
		sda_low_d = sda_low_q;
		if (start_det) begin
			state_d   = sbi_pkg::ST_DEV;
			sda_low_d = 1'b0;
		end else if (stop_det) begin
			state_d   = sbi_pkg::ST_IDLE;
			sda_low_d = 1'b0;
		end else if (scl_fall) begin
			unique case (state_q)
				sbi_pkg::ST_IDLE: begin
				end
				sbi_pkg::ST_DEV: begin
					if (byte_end) begin
						state_d   = addr_hit ? sbi_pkg::ST_DEV_ACK : sbi_pkg::ST_IDLE;
						sda_low_d = addr_hit;
					end
				end
				sbi_pkg::ST_PTR_HI: begin
					if (byte_end) begin
						state_d   = sbi_pkg::ST_HI_ACK;
						sda_low_d = 1'b1;
					end
				end
				sbi_pkg::ST_PTR_LO: begin
					if (byte_end) begin
						state_d   = sbi_pkg::ST_LO_ACK;
						sda_low_d = 1'b1;
					end
				end
				sbi_pkg::ST_WDATA: begin
					if (byte_end) begin
						state_d   = sbi_pkg::ST_WR_ACK;
						sda_low_d = 1'b1;
					end
				end
				sbi_pkg::ST_DEV_ACK: begin
					// read starts with the buffered register
					state_d   = rw_q ? sbi_pkg::ST_RDATA : sbi_pkg::ST_PTR_HI;
					sda_low_d = rw_q & ~rd_buf_q[7];
				end
				sbi_pkg::ST_HI_ACK: begin
					state_d   = sbi_pkg::ST_PTR_LO;
					sda_low_d = 1'b0;
				end
				sbi_pkg::ST_LO_ACK: begin
					state_d   = sbi_pkg::ST_WDATA;
					sda_low_d = 1'b0;
				end
				sbi_pkg::ST_WR_ACK: begin
					state_d   = sbi_pkg::ST_WDATA;
					sda_low_d = 1'b0;
				end
				sbi_pkg::ST_RDATA: begin
					if (byte_end) begin
						state_d   = sbi_pkg::ST_RD_ACK;
						sda_low_d = 1'b0;
					end else begin
						sda_low_d = ~tx_q[6];
					end
				end
				sbi_pkg::ST_RD_ACK: begin
					state_d   = mack_q ? sbi_pkg::ST_RDATA : sbi_pkg::ST_IDLE;
					sda_low_d = mack_q & ~rd_buf_q[7];
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q   <= sbi_pkg::ST_IDLE;
			sda_low_q <= 1'b0;
		end else begin
			state_q   <= state_d;
			sda_low_q <= sda_low_d;
		end
	end

	// -----------------------------------------------------------------
	// Bit counter and shifters
	// -----------------------------------------------------------------
	// MSB first in both directions
	always_ff @(posedge clk_sys) begin
		if (rst | start_det | byte_end) begin
			bit_cnt_q <= 4'h0;
		end else if (scl_rise & in_byte) begin
			bit_cnt_q <= bit_cnt_q + 4'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			shift_q <= 8'h00;
		end else if (scl_rise & in_byte) begin
			shift_q <= {shift_q[6:0], sda_f};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tx_q <= 8'h00;
		end else if (state_d == sbi_pkg::ST_RDATA && state_q != sbi_pkg::ST_RDATA) begin
			tx_q <= rd_buf_q;
		end else if (scl_fall & (state_q == sbi_pkg::ST_RDATA)) begin
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rw_q   <= 1'b0;
			mack_q <= 1'b0;
		end else begin
			if (byte_end & in_dev) begin
				rw_q <= shift_q[0];
			end
			if (scl_rise & in_rdack) begin
				mack_q <= ~sda_f;
			end
		end
	end

	// -----------------------------------------------------------------
	// Register pointer
	// -----------------------------------------------------------------
	// START never touches the pointer, so it survives a restart.
	// Only rst clears it; nothing else disturbs it while idle.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ptr_q <= sbi_pkg::PTR_RESET;
		end else if (byte_end & (state_q == sbi_pkg::ST_PTR_HI)) begin
			ptr_q[15:8] <= shift_q;
		end else if (byte_end & (state_q == sbi_pkg::ST_PTR_LO)) begin
			ptr_q[7:0] <= shift_q;
		end else if (ptr_step) begin
			ptr_q <= ptr_q + 16'h0001;
		end
	end

	// -----------------------------------------------------------------
	// Register side strobes
	// -----------------------------------------------------------------
	// The write lands before the pointer steps at the next rising clock.
	// A read is fetched at the read address byte, then only after a master acknowledge, so no register is read
	// ahead when the master ends the transfer.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_en_q   <= 1'b0;
			wr_data_q <= 8'h00;
			rd_step_q <= 1'b0;
			rd_req_q  <= 1'b0;
			rd_take_q <= 1'b0;
			rd_buf_q  <= 8'h00;
		end else begin
			wr_en_q   <= byte_end & (state_q == sbi_pkg::ST_WDATA);
			wr_data_q <= byte_end ? shift_q : wr_data_q;
			rd_step_q <= scl_rise & in_rdack & ~sda_f;
			rd_req_q  <= dev_read | rd_step_q;
			rd_take_q <= rd_req_q;
			rd_buf_q  <= rd_take_q ? reg_rd_data : rd_buf_q;
		end
	end

	// -----------------------------------------------------------------
	// Bus address
	// -----------------------------------------------------------------
	// Straps are sampled once, in the first cycle after reset release, unless dev_addr_load is high in that cycle.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			strap_done_q <= 1'b0;
			dev_addr_q   <= sbi_pkg::DEV_ADDR_RESET;
		end else if (dev_addr_load) begin
			strap_done_q <= 1'b1;
			dev_addr_q   <= dev_addr_new;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			dev_addr_q   <= strap_map(addr_strap);
		end
	end

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_start_restart: assert property (start_det |=> state_q == sbi_pkg::ST_DEV && !sda_low_q)
		else $error("START did not restart the address phase");

	a_stop_idle: assert property (stop_det |=> state_q == sbi_pkg::ST_IDLE && !sda_low_q)
		else $error("STOP did not return to idle");

	a_drive_edge: assert property ($changed(sda_low_q) |-> $past(scl_fall | start_det | stop_det))
		else $error("Data drive changed outside a falling clock");

	a_addr_ack: assert property ((in_dev && byte_end && addr_hit) |=>
		state_q == sbi_pkg::ST_DEV_ACK && sda_low_q)
		else $error("Matching address not acknowledged");

	a_ack_hold: assert property (state_q == sbi_pkg::ST_DEV_ACK |-> sda_low_q)
		else $error("Address acknowledge released before the clock fell");

	a_ptr_step: assert property ((in_wrack || in_rdack) && scl_rise |=>
		ptr_q == $past(ptr_q) + 16'h0001)
		else $error("Pointer did not step at acknowledge");

	a_read_release: assert property (in_rdack |-> !sda_low_q)
		else $error("Data line driven during master acknowledge");

	a_nack_idle: assert property (in_rdack && scl_fall && !mack_q && !start_det && !stop_det |=>
		state_q == sbi_pkg::ST_IDLE ##1 !sda_low_q)
		else $error("Read without acknowledge did not go idle");

	a_ptr_hold: assert property (state_q == sbi_pkg::ST_IDLE |=> $stable(ptr_q))
		else $error("Pointer changed while idle");

	a_read_fetch: assert property (dev_read |=> reg_rd_en ##2 rd_buf_q == $past(reg_rd_data))
		else $error("Read data not fetched at current pointer");

endmodule

// File: logic/sbi_pkg.sv
// Constants, timing counts and state type of the two-wire control slave.
package sbi_pkg;

	// -----------------------------------------------------------------
	// Clock and line timing
	// -----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned MAX_BIT_RATE  = 400000;
	localparam int unsigned FILTER_NS     = 50;
	// Least time rounds up to whole cycles.
	localparam int unsigned FILTER_CYC    = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// -----------------------------------------------------------------
	// Bus addresses and reset values
	// -----------------------------------------------------------------
	localparam logic [6:0]  STRAP0_ADDR     = 7'h2C;
	localparam logic [6:0]  STRAP1_ADDR     = 7'h2D;
	localparam logic [6:0]  STRAP2_ADDR     = 7'h36;
	localparam logic [6:0]  STRAP_RSVD_ADDR = 7'h7F;
	localparam logic [6:0]  BCAST_ADDR      = 7'h00;
	localparam logic [6:0]  DEV_ADDR_RESET  = 7'h7F;
	localparam logic [15:0] PTR_RESET       = 16'h0000;
	localparam logic [3:0]  BYTE_BITS       = 4'h8;
	localparam logic        LINE_IDLE       = 1'b1;

	// -----------------------------------------------------------------
	// Transfer phases
	// -----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE, ST_DEV, ST_DEV_ACK, ST_PTR_HI, ST_HI_ACK, ST_PTR_LO,
		ST_LO_ACK, ST_WDATA, ST_WR_ACK, ST_RDATA, ST_RD_ACK
	} phase_t;

endpackage

// File: logic/line_filter.sv
// Synchroniser and glitch filter for one bus line.
`timescale 1ns/1ps
module line_filter #(
	parameter int unsigned STABLE_CYC = sbi_pkg::FILTER_CYC
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic line_in,
	output logic      line_q
);

	localparam int unsigned CW = $clog2(STABLE_CYC + 1);

	logic          meta_q;
	logic          sync_q;
	logic [CW-1:0] cnt_q;

	// -----------------------------------------------------------------
	// Two-stage synchroniser; the first stage feeds only the second.
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_q <= sbi_pkg::LINE_IDLE;
			sync_q <= sbi_pkg::LINE_IDLE;
		end else begin
			meta_q <= line_in;
			sync_q <= meta_q;
		end
	end

	// A new level is accepted only after it held for STABLE_CYC cycles,
	// which drops spikes yet stays far below the shortest clock phase.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt_q  <= '0;
			line_q <= sbi_pkg::LINE_IDLE;
		end else if (sync_q == line_q) begin
			cnt_q <= '0;
		end else if (cnt_q == CW'(STABLE_CYC - 1)) begin
			cnt_q  <= '0;
			line_q <= sync_q;
		end else begin
			cnt_q <= cnt_q + CW'(1);
		end
	end

endmodule

// File: tb/bus_master_model.sv
// Behavioural two-wire bus master that drives the control slave from the far side.
`timescale 1ns/1ps
module bus_master_model #(
	// A quarter bit of 80 cycles gives about 390 kbit/s, under the limit.
	parameter int unsigned QTR = 80
) (
	input  wire logic clk_sys,
	input  wire logic data_wire,
	output logic      clk_line,
	output logic      data_drv
);
	// -----------------------------------------------------------------
	// Line control
	// -----------------------------------------------------------------
	// Both lines idle high, as the pull-ups would hold them.
	initial begin
		clk_line = 1'b1;
		data_drv = 1'b1;
	end

	// Lines move only at falling system edges, clear of the slave's sampling.
	task automatic qwait();
		repeat (QTR) @(negedge clk_sys);
	endtask

	// START: data falls while the clock is high, also as a repeated start.
	task automatic start();
		data_drv = 1'b1;
		qwait();
		clk_line = 1'b1;
		qwait();
		data_drv = 1'b0;
		qwait();
		clk_line = 1'b0;
		qwait();
	endtask

	// STOP: data rises while the clock stays high.
	task automatic stop();
		data_drv = 1'b0;
		qwait();
		clk_line = 1'b1;
		qwait();
		data_drv = 1'b1;
		qwait();
	endtask

	// One bit slot; data changes only while the clock is low.
	task automatic bit_io(input logic b, output logic r);
		data_drv = b;
		qwait();
		clk_line = 1'b1;
		qwait();
		r = data_wire;
		qwait();
		clk_line = 1'b0;
		qwait();
	endtask

	// Eight bits MSB first, then the acknowledge slot left to the slave.
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask

	// Acknowledge to go on reading; the final byte is left unacknowledged.
	task automatic rd_byte(input logic ack, output logic [7:0] d, output logic slot);
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(~ack, slot);
	endtask
endmodule

// File: tb/sensor_two_wire_control_slave_tb.sv
// Self-checking testbench of the two-wire control slave.
`timescale 1ns/1ps
module sensor_two_wire_control_slave_tb;
	logic        clk_sys = 1'b0;
	logic        rst;
	logic [1:0]  addr_strap;
	logic        dev_addr_load;
	logic [6:0]  dev_addr_new;
	logic        clk_line;
	logic        data_drv;
	wire  logic  data_wire;
	logic        oe;
	logic        out;
	logic [15:0] reg_addr;
	logic        reg_wr_en;
	logic [7:0]  reg_wr_data;
	logic        reg_rd_en;
	logic [7:0]  reg_rd_data = 8'h00;
	logic        bus_active;
	logic [7:0]  mem [65536];
	bit          written [65536];
	logic [23:0] wr_log [$];
	int          miscompares = 0;
	int          n_compared = 0;

	// -----------------------------------------------------------------
	// Harness
	// -----------------------------------------------------------------
	// Open-drain wire: low if either party pulls it.
	assign data_wire = ~oe & data_drv;

	always #4 clk_sys = ~clk_sys;

	bus_master_model i_mst (
		.clk_sys   (clk_sys),
		.data_wire (data_wire),
		.clk_line  (clk_line),
		.data_drv  (data_drv)
	);

	serial_bus_logic i_dut (
		.clk_sys                (clk_sys),
		.rst                    (rst),
		.addr_strap             (addr_strap),
		.dev_addr_load          (dev_addr_load),
		.dev_addr_new           (dev_addr_new),
		.ctrl_bus_clk_line      (clk_line),
		.ctrl_bus_data_line_in  (data_wire),
		.ctrl_bus_data_line_out (out),
		.ctrl_bus_data_line_oe  (oe),
		.reg_addr               (reg_addr),
		.reg_wr_en              (reg_wr_en),
		.reg_wr_data            (reg_wr_data),
		.reg_rd_en              (reg_rd_en),
		.reg_rd_data            (reg_rd_data),
		.bus_active             (bus_active)
	);

	// Unwritten registers read a pattern so a wrong pointer shows up.
	function automatic logic [7:0] rd_val(input logic [15:0] a);
		return written[a] ? mem[a] : (a[7:0] ^ 8'h5A);
	endfunction

	// Register store: writes logged, read data ready half a cycle after the strobe.
	always @(posedge clk_sys) begin
		if (reg_wr_en === 1'b1) begin
			mem[reg_addr] = reg_wr_data;
			written[reg_addr] = 1'b1;
			wr_log.push_back({reg_addr, reg_wr_data});
		end
	end
	always @(negedge clk_sys) begin
		if (reg_rd_en === 1'b1) begin
			reg_rd_data = rd_val(reg_addr);
		end
	end

	// -----------------------------------------------------------------
	// Shared tasks
	// -----------------------------------------------------------------
	task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic stop_test();
		chk("open drain out", 24'h000000, {23'h000000, out});
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic do_reset();
		rst = 1'b1;
		repeat (12) @(negedge clk_sys);
		rst = 1'b0;
		repeat (4) @(negedge clk_sys);
	endtask

	task automatic wb(input logic [7:0] d, input logic exp_ack);
		logic a;
		i_mst.wr_byte(d, a);
		chk("ack", {23'h000000, exp_ack}, {23'h000000, a});
	endtask

	task automatic rb(input logic ack, input logic [7:0] exp);
		logic [7:0] d;
		logic       s;
		i_mst.rd_byte(ack, d, s);
		chk("read data", {16'h0000, exp}, {16'h0000, d});
		chk("ack slot", {23'h000000, ~ack}, {23'h000000, s});
	endtask

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	// Three data bytes cross a page of the pointer.
	task automatic multi_write();
		wr_log.delete();
		i_mst.start();
		wb(8'h58, 1'b1);
		wb(8'h12, 1'b1);
		wb(8'hFE, 1'b1);
		wb(8'hA1, 1'b1);
		wb(8'hB2, 1'b1);
		wb(8'hC3, 1'b1);
		i_mst.stop();
		chk("write count", 24'h000003, 24'(wr_log.size()));
		chk("write 0", 24'h12FEA1, wr_log[0]);
		chk("write 1", 24'h12FFB2, wr_log[1]);
		chk("write 2", 24'h1300C3, wr_log[2]);
		chk("pointer", 24'h001301, {8'h00, reg_addr});
		chk("idle after stop", 24'h000000, {23'h000000, bus_active});
	endtask

	// Dummy write, repeated start, three reads, last one unacknowledged.
	task automatic random_read();
		i_mst.start();
		wb(8'h58, 1'b1);
		wb(8'h12, 1'b1);
		wb(8'hFE, 1'b1);
		i_mst.start();
		wb(8'h59, 1'b1);
		rb(1'b1, 8'hA1);
		rb(1'b1, 8'hB2);
		rb(1'b0, 8'hC3);
		chk("idle after nack", 24'h000000, {23'h000000, bus_active});
		i_mst.stop();
	endtask

	// Read at the pointer left by the previous transaction.
	task automatic current_read();
		i_mst.start();
		wb(8'h59, 1'b1);
		rb(1'b0, rd_val(16'h1301));
		i_mst.stop();
	endtask

	// Start in mid-byte abandons the write; broadcast then writes.
	task automatic abort_then_bcast();
		logic r;
		wr_log.delete();
		i_mst.start();
		wb(8'h58, 1'b1);
		wb(8'h33, 1'b1);
		i_mst.bit_io(1'b0, r);
		i_mst.bit_io(1'b1, r);
		i_mst.start();
		wb(8'h00, 1'b1);
		wb(8'h00, 1'b1);
		wb(8'h40, 1'b1);
		wb(8'h77, 1'b1);
		i_mst.stop();
		chk("write count", 24'h000001, 24'(wr_log.size()));
		chk("broadcast write", 24'h004077, wr_log[0]);
	endtask

	// A loaded address replaces the strapped one.
	task automatic addr_override();
		dev_addr_new = 7'h11;
		dev_addr_load = 1'b1;
		@(negedge clk_sys);
		dev_addr_load = 1'b0;
		i_mst.start();
		wb(8'h22, 1'b1);
		i_mst.start();
		wb(8'h58, 1'b0);
		i_mst.stop();
	endtask

	// Each other strap value answers its own address and refuses the first.
	task automatic strap_select();
		logic [6:0] own [3];
		own = '{7'h2D, 7'h36, sbi_pkg::STRAP_RSVD_ADDR};
		for (int s = 1; s < 4; s++) begin
			addr_strap = 2'(s);
			do_reset();
			i_mst.start();
			wb({own[s-1], 1'b0}, 1'b1);
			i_mst.start();
			wb(8'h58, 1'b0);
			i_mst.stop();
		end
	endtask

	// -----------------------------------------------------------------
	// Sequence and watchdog
	// -----------------------------------------------------------------
	// Inputs settle at time zero; later changes land on falling edges.
	initial begin
		rst = 1'b1;
		addr_strap = 2'h0;
		dev_addr_load = 1'b0;
		dev_addr_new = 7'h00;
		do_reset();
		multi_write();
		random_read();
		current_read();
		abort_then_bcast();
		addr_override();
		strap_select();
		stop_test();
	end

	// About 91k cycles of traffic are planned; a small margin cuts a hang
	// while keeping the whole run under the cycle budget.
	initial begin
		repeat (97000) @(posedge clk_sys);
		miscompares++;
		stop_test();
	end
endmodule
